//--- logic/usart_ctrl_defines.vh
/*
 * Register offsets, field positions and reset values for the serial
 * control and status slice. Assumes byte-wide registers on a plain port.
 */
`ifndef USART_CTRL_DEFINES_VH
`define USART_CTRL_DEFINES_VH

// Register offsets
`define OFS_TX_LOW_BYTE     4'h2
`define OFS_TX_NINTH_BIT    4'h3
`define OFS_STATUS_FLAGS    4'h4
`define OFS_IRQ_CTRL        4'h5
`define OFS_ENABLE_CTRL     4'h6
`define OFS_CHAR_CTRL       4'h7

// Status bit positions
`define ST_RXC              7
`define ST_TXC              6
`define ST_DRE              5
`define ST_RXS              4
`define ST_ISF              3
`define ST_BDF              1
`define ST_WFB              0

// Control A bit positions
`define CA_RECEIVE_COMPLETE_IRQ_EN            7
`define CA_TRANSMIT_COMPLETE_IRQ_EN            6
`define CA_DATA_EMPTY_IRQ_EN            5
`define CA_START_FRAME_IRQ_EN            4
`define CA_LOOPBACK_ENABLE             3
`define CA_AUTOBAUD_ERROR_IRQ_EN            2

// Control B bit positions
`define CB_RECEIVER_ENABLE             7
`define CB_TRANSMITTER_ENABLE             6
`define CB_START_FRAME_DETECT_EN            4
`define CB_OPEN_DRAIN_ENABLE             3

// Field codes
`define RS485_OFF           2'h0
`define RS485_EXT           2'h1
`define RS485_INT           2'h2
`define RXM_GENERIC_AUTOBAUD_MODE         2'h2
`define RXM_CONSTRAINED_AUTOBAUD_MODE         2'h3
`define CHSZ_9_LOW_FIRST    3'h6
`define CHSZ_9_HIGH_FIRST   3'h7
`define SYNC_CHAR           8'h55
`define BREAK_BITS          8'h0B

// Reset values
`define RST_CTRL            8'h00
`define RST_CHAR_CTRL       8'h03

`endif

//--- logic/usart_status_control_regs.v
/*
 * Control and status registers of a serial transceiver: transmit
 * buffer handshake, status flags, vector requests, pin ownership.
 * Assumes a shift datapath outside that reports its events as pulses
 * on i_mclk and a receive buffer level; the receive pin is asynchronous.
 */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`include "usart_ctrl_defines.vh"

////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Receive flag follows unread buffer data
// - Transmit done when shifter and buffer empty
// - Transmit done cleared by vector or one
// - Data empty flag set after reset
// - Low byte write clears empty; else ignored
// - Start flag in standby, clear by one
// - Inconsistent sync on bad timing, or bad char in constrained mode
// - Clearing sync flag resets autobaud logic
// - Break flag after break plus sync
// - Break flag clears on next data
// - Wait-for-break arms break, reads zero
// - Enables gate the three vectors
// - Start frame requests receive vector
// - Autobaud error requests receive vector
// - Loop-back ties transmit to receive
// - Driver mode off, external, internal
// - Receiver disable flushes and resets autobaud
// - Transmitter disable waits for empty
// - Start detect wakes; open drain low only
// - Receiver mode field encodings
// - Nine-bit byte order codes
module usart_status_control_regs (
    // Clock, reset, enable
    input  wire       i_mclk,
    input  wire       i_rstn,
    input  wire       i_ce,
    // Register port
    input  wire [3:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    // Datapath status
    input  wire       i_rx_unread,
    input  wire       i_tx_shift_busy,
    input  wire       i_tx_load,
    input  wire       i_sync_bad,
    input  wire       i_sync_byte_done,
    input  wire [7:0] i_sync_byte,
    input  wire       i_break_seen,
    input  wire       i_rx_char_done,
    input  wire       i_txc_vector_ack,
    input  wire       i_standby,
    input  wire       i_tx_serial,
    // Pins
    input  wire       i_rxd_pin,
    output reg        o_txd_out,
    output reg        o_txd_oe,
    output reg        o_driver_enable_pin,
    // Datapath control
    output reg  [8:0] o_tx_word,
    output reg        o_tx_valid,
    output reg        o_rx_line,
    output reg        o_rx_flush,
    output reg        o_autobaud_reset,
    output reg        o_wait_break,
    output reg  [1:0] o_receiver_mode,
    output reg  [2:0] o_character_size,
    output reg        o_wake,
    // Vector requests
    output reg        o_receive_vector,
    output reg        o_transmit_done_vector,
    output reg        o_data_empty_vector
);

////////////////////////////////////////////////////////////////////////
reg  [1:0] rst_sync_r;
wire       rstn = rst_sync_r[1];

always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn)
        rst_sync_r <= 2'h0;
    else
        rst_sync_r <= {rst_sync_r[0], 1'b1};
end

// Pin input through two stages
reg  [1:0] rxd_sync_r;
always @(posedge i_mclk or negedge rstn) begin
    if (!rstn)
        rxd_sync_r <= 2'h3;
    else if (i_ce)
        rxd_sync_r <= {rxd_sync_r[0], i_rxd_pin};
end

////////////////////////////////////////////////////////////////////////
reg  [7:0] tx_low_byte_r;
reg        tx_ninth_bit_r;
reg  [7:0] irq_loopback_driver_ctrl_r;
reg  [7:0] rx_tx_enable_ctrl_r;
reg  [7:0] char_ctrl_r;
reg        txc_r, dre_r, rxs_r, isf_r, bdf_r;
reg        tx_active_r;
reg        rx_prev_r;
reg        wfb_r;

wire wr_st  = i_wr && (i_addr == `OFS_STATUS_FLAGS);
wire wr_lo  = i_wr && (i_addr == `OFS_TX_LOW_BYTE);
wire rx_en  = rx_tx_enable_ctrl_r[`CB_RECEIVER_ENABLE];
wire sfd_en = rx_tx_enable_ctrl_r[`CB_START_FRAME_DETECT_EN];
wire autob  = rx_tx_enable_ctrl_r[2:1] == `RXM_GENERIC_AUTOBAUD_MODE || rx_tx_enable_ctrl_r[2:1] == `RXM_CONSTRAINED_AUTOBAUD_MODE;
wire linm   = rx_tx_enable_ctrl_r[2:1] == `RXM_CONSTRAINED_AUTOBAUD_MODE;
wire rx_line = irq_loopback_driver_ctrl_r[`CA_LOOPBACK_ENABLE] ? i_tx_serial : rxd_sync_r[1];
wire tx_empty_all = dre_r && !i_tx_shift_busy;

function clr1;
    input en;
    input [7:0] d;
    input integer b;
    begin
        clr1 = en && d[b];
    end
endfunction

always @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
        tx_low_byte_r  <= 8'h00;
        tx_ninth_bit_r <= 1'b0;
        irq_loopback_driver_ctrl_r        <= `RST_CTRL;
        rx_tx_enable_ctrl_r        <= `RST_CTRL;
        char_ctrl_r    <= `RST_CHAR_CTRL;
        txc_r          <= 1'b0;
        dre_r          <= 1'b1;
        rxs_r          <= 1'b0;
        isf_r          <= 1'b0;
        bdf_r          <= 1'b0;
        tx_active_r    <= 1'b0;
        rx_prev_r      <= 1'b1;
        wfb_r          <= 1'b0;
    end else if (i_ce) begin
        rx_prev_r <= rx_line;
        if (i_wr && i_addr == `OFS_TX_NINTH_BIT)
            tx_ninth_bit_r <= i_wdata[0];
        if (i_wr && i_addr == `OFS_IRQ_CTRL)
            irq_loopback_driver_ctrl_r <= i_wdata;
        if (i_wr && i_addr == `OFS_ENABLE_CTRL)
            rx_tx_enable_ctrl_r <= {i_wdata[7:6], 1'b0, i_wdata[4:0]};
        if (i_wr && i_addr == `OFS_CHAR_CTRL)
            char_ctrl_r <= i_wdata;
        if (wr_lo && dre_r)
            tx_low_byte_r <= i_wdata;
        if (wr_lo && dre_r)
            dre_r <= 1'b0;
        else if (i_tx_load)
            dre_r <= 1'b1;
        // done when all empty; set wins clear
        if (tx_active_r && !i_tx_shift_busy && dre_r && !i_tx_load)
            txc_r <= 1'b1;
        else if (i_txc_vector_ack || clr1(wr_st, i_wdata, `ST_TXC))
            txc_r <= 1'b0;
        tx_active_r <= i_tx_shift_busy || i_tx_load;
        if (sfd_en && i_standby && rx_prev_r && !rx_line)
            rxs_r <= 1'b1;
        else if (clr1(wr_st, i_wdata, `ST_RXS) || !sfd_en)
            rxs_r <= 1'b0;
        // bad timing, or wrong sync char in constrained mode
        if (autob && (i_sync_bad ||
            (linm && i_sync_byte_done && i_sync_byte != `SYNC_CHAR)))
            isf_r <= 1'b1;
        else if (clr1(wr_st, i_wdata, `ST_ISF))
            isf_r <= 1'b0;
        // break plus sync; next data clears
        if (autob && i_break_seen && i_sync_byte_done && !i_sync_bad)
            bdf_r <= 1'b1;
        else if (clr1(wr_st, i_wdata, `ST_BDF) || i_rx_char_done || !autob)
            bdf_r <= 1'b0;
        if (clr1(wr_st, i_wdata, `ST_WFB))
            wfb_r <= 1'b1;
        else if (!rx_prev_r && rx_line)
            wfb_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// flag is the buffer level, gated by enable
wire receive_vector = i_rx_unread && rx_en;
// wake on start edge when enabled
wire wake = sfd_en && rx_prev_r && !rx_line;
// transmitter keeps pin until all empty
reg  tx_own_r;
wire [1:0] rs485 = irq_loopback_driver_ctrl_r[1:0];
wire tx_busy = i_tx_shift_busy || !dre_r;

always @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
        tx_own_r               <= 1'b0;
        o_rdata                <= 8'h00;
        o_txd_out              <= 1'b1;
        o_txd_oe               <= 1'b0;
        o_driver_enable_pin    <= 1'b0;
        o_tx_word              <= 9'h000;
        o_tx_valid             <= 1'b0;
        o_rx_line              <= 1'b1;
        o_rx_flush             <= 1'b1;
        o_autobaud_reset       <= 1'b1;
        o_wait_break           <= 1'b0;
        o_receiver_mode        <= 2'h0;
        o_character_size       <= 3'h3;
        o_wake                 <= 1'b0;
        o_receive_vector       <= 1'b0;
        o_transmit_done_vector <= 1'b0;
        o_data_empty_vector    <= 1'b0;
    end else if (i_ce) begin
        if (rx_tx_enable_ctrl_r[`CB_TRANSMITTER_ENABLE])
            tx_own_r <= 1'b1;
        else if (tx_empty_all)
            tx_own_r <= 1'b0;
        o_txd_out <= i_tx_serial;
        o_txd_oe  <= tx_own_r && (rs485 != `RS485_INT || tx_busy) &&
                     !(rx_tx_enable_ctrl_r[`CB_OPEN_DRAIN_ENABLE] && i_tx_serial);
        o_driver_enable_pin <= (rs485 == `RS485_EXT) && tx_own_r && tx_busy;
        o_tx_word  <= {tx_ninth_bit_r, tx_low_byte_r};
        o_tx_valid <= !dre_r && tx_own_r;
        o_rx_line  <= rx_en ? rx_line : 1'b1;
        o_rx_flush       <= !rx_en;
        o_autobaud_reset <= (!rx_en && autob) || clr1(wr_st, i_wdata, `ST_ISF);
        o_wait_break     <= wfb_r;
        o_receiver_mode  <= rx_tx_enable_ctrl_r[2:1];
        o_character_size <= char_ctrl_r[2:0];
        o_wake           <= wake;
        // enabled flags request; extra receive sources
        o_receive_vector <= (irq_loopback_driver_ctrl_r[`CA_RECEIVE_COMPLETE_IRQ_EN] && receive_vector) ||
                            (irq_loopback_driver_ctrl_r[`CA_START_FRAME_IRQ_EN] && rxs_r) ||
                            (irq_loopback_driver_ctrl_r[`CA_AUTOBAUD_ERROR_IRQ_EN] && isf_r);
        o_transmit_done_vector <= irq_loopback_driver_ctrl_r[`CA_TRANSMIT_COMPLETE_IRQ_EN] && txc_r;
        o_data_empty_vector    <= irq_loopback_driver_ctrl_r[`CA_DATA_EMPTY_IRQ_EN] && dre_r;
        if (i_rd) begin
            case (i_addr)
                `OFS_TX_LOW_BYTE:  o_rdata <= tx_low_byte_r;
                `OFS_TX_NINTH_BIT: o_rdata <= {7'h00, tx_ninth_bit_r};
                `OFS_STATUS_FLAGS: o_rdata <= {receive_vector, txc_r, dre_r,
                                               rxs_r && sfd_en, isf_r,
                                               1'b0, bdf_r, 1'b0};
                `OFS_IRQ_CTRL:     o_rdata <= irq_loopback_driver_ctrl_r;
                `OFS_ENABLE_CTRL:  o_rdata <= rx_tx_enable_ctrl_r;
                `OFS_CHAR_CTRL:    o_rdata <= char_ctrl_r;
                default:           o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end
end

endmodule // usart_status_control_regs

//--- tb/serial_node.sv
/* Remote serial node on the receive and transmit lines.
   Assumes one bench clock; the transmit line carries a pull-up, the receive line is driven. */
`timescale 1ns/100ps
module serial_node #(parameter BIT_CYC = 8) (
    // Clock
    input  wire i_clk,
    // Lines
    input  wire i_txd_out,
    input  wire i_txd_oe,
    output reg  o_rxd,
    output wire o_txd_wire
);
    assign o_txd_wire = i_txd_oe ? i_txd_out : 1'b1;
    initial o_rxd = 1'b1;
    ////////////////////////////////////////////////////////////////
    // idle high, start low
    task send(input [7:0] b);
        integer k;
        begin
            for (k = 0; k < 10; k = k + 1) begin
                o_rxd <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : b[(k + 7) % 8];
                repeat (BIT_CYC) @(posedge i_clk);
            end
        end
    endtask
endmodule // serial_node

//--- tb/usart_status_control_regs_asserts.sv
/* Port checker for the status slice.
   Assumes it is bound to usart_status_control_regs. */
`timescale 1ns/100ps
`include "usart_ctrl_defines.vh"
module usart_regs_checker (
    input wire       i_mclk,
    input wire       i_rstn,
    input wire       i_ce,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    input wire       i_rd,
    input wire [7:0] o_rdata,
    input wire       i_rx_unread,
    input wire       i_tx_shift_busy,
    input wire       i_txc_vector_ack,
    input wire       o_tx_valid,
    input wire [8:0] o_tx_word,
    input wire       o_rx_flush,
    input wire       o_autobaud_reset,
    input wire [1:0] o_receiver_mode,
    input wire [2:0] o_character_size,
    input wire       o_transmit_done_vector
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    wire rd_st = i_rd && i_ce && i_addr == `OFS_STATUS_FLAGS;
    wire wr_ok = i_wr && i_ce;
    AST_RXC_EMPTY: assert property (rd_st && !i_rx_unread && !$past(i_rx_unread)
        |=> !o_rdata[`ST_RXC]) else $error("receive flag set with empty buffer");
    AST_WFB_ZERO: assert property (rd_st |=> !o_rdata[`ST_WFB] && !o_rdata[2])
        else $error("wait bit or spare bit reads one");
    AST_TX_LOAD: assert property ($rose(o_tx_valid)
        |-> $past(wr_ok && i_addr == `OFS_TX_LOW_BYTE, 2)) else $error("buffer full w/o write");
    AST_TX_WORD: assert property ($rose(o_tx_valid) |-> o_tx_word[7:0] == $past(i_wdata, 2))
        else $error("buffer byte differs from write");
    AST_TXC_ACK: assert property (i_txc_vector_ack && !i_tx_shift_busy
        |-> ##[1:3] !o_transmit_done_vector) else $error("done request kept after vector");
    AST_ISF_RESET: assert property ($past(wr_ok && i_addr == `OFS_STATUS_FLAGS
        && i_wdata[`ST_ISF]) |-> ##[0:2] o_autobaud_reset) else $error("no autobaud reset");
    AST_FLUSH: assert property ($past(wr_ok && i_addr == `OFS_ENABLE_CTRL
        && !i_wdata[`CB_RECEIVER_ENABLE]) |-> ##[0:2] o_rx_flush) else $error("no flush on disable");
    AST_MODE: assert property ($past(wr_ok && i_addr == `OFS_ENABLE_CTRL)
        |=> o_receiver_mode == $past(i_wdata[2:1], 2)) else $error("receiver mode lost");
    AST_CHARACTER_SIZE: assert property ($past(wr_ok && i_addr == `OFS_CHAR_CTRL)
        |=> o_character_size == $past(i_wdata[2:0], 2)) else $error("character size lost");
    cover property ($rose(o_tx_valid));
    cover property (o_transmit_done_vector ##1 !o_transmit_done_vector);
    cover property ($rose(o_rx_flush));
endmodule // usart_regs_checker
bind usart_status_control_regs usart_regs_checker u_chk (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_rx_unread(i_rx_unread), .i_tx_shift_busy(i_tx_shift_busy),
    .i_txc_vector_ack(i_txc_vector_ack), .o_tx_valid(o_tx_valid), .o_tx_word(o_tx_word),
    .o_rx_flush(o_rx_flush), .o_autobaud_reset(o_autobaud_reset),
    .o_receiver_mode(o_receiver_mode), .o_character_size(o_character_size),
    .o_transmit_done_vector(o_transmit_done_vector));

//--- tb/testbench.sv
/* Self-checking bench for the status slice.
   Assumes a serial node model and a bound checker. */
`timescale 1ns/100ps
`include "usart_ctrl_defines.vh"
module testbench;
    logic       i_mclk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, rd_d = 0, woke = 0;
    logic       busy = 0, unread = 0, brk = 0, stby = 0, tser = 1;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, sync = 8'h00, d, rdata;
    logic [4:0] pls = 5'h00;
    logic [8:0] word;
    logic       rxd, txd, oe, wire_tx, flush, wake, rxv, txv, wbk, dev;
    logic [7:0] exp_q[$], msk_q[$];
    integer     failures = 0, comparisons = 0, seed = 15651, i;
    initial forever #5 i_mclk = ~i_mclk;
    usart_status_control_regs u_usart_status_control_regs (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(rdata), .i_rx_unread(unread), .i_tx_shift_busy(busy), .i_tx_load(pls[0]),
        .i_sync_bad(pls[1]), .i_sync_byte_done(pls[2]), .i_sync_byte(sync),
        .i_break_seen(brk), .i_rx_char_done(pls[3]), .i_txc_vector_ack(pls[4]),
        .i_standby(stby), .i_tx_serial(tser), .i_rxd_pin(rxd), .o_txd_out(txd),
        .o_txd_oe(oe), .o_driver_enable_pin(), .o_tx_word(word), .o_tx_valid(),
        .o_rx_line(), .o_rx_flush(flush), .o_autobaud_reset(), .o_wait_break(wbk),
        .o_receiver_mode(), .o_character_size(), .o_wake(wake), .o_receive_vector(rxv),
        .o_transmit_done_vector(txv), .o_data_empty_vector(dev));
    serial_node u_serial_node (.i_clk(i_mclk), .i_txd_out(txd), .i_txd_oe(oe),
        .o_rxd(rxd), .o_txd_wire(wire_tx));
    ////////////////////////////////////////////////////////////////
    task tick(input integer n); repeat (n) @(posedge i_mclk); endtask
    task chk(input [8:0] got, input [8:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input [3:0] a, input [7:0] v);
        @(posedge i_mclk); i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
        @(posedge i_mclk); i_wr <= 1'b0;
    endtask
    task rd(input [3:0] a, input [7:0] e, input [7:0] m);
        @(posedge i_mclk); i_addr <= a; i_rd <= 1'b1; exp_q.push_back(e); msk_q.push_back(m);
        @(posedge i_mclk); i_rd <= 1'b0;
    endtask
    task pulse(input integer b);
        @(posedge i_mclk); pls <= 5'h01 << b;
        @(posedge i_mclk); pls <= 5'h00;
        tick(3);
    endtask
    task close_out;
        if (failures == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Read data stands one cycle after the strobe
    always @(posedge i_mclk) begin
        rd_d <= i_rd;
        if (wake === 1'b1) woke <= 1'b1;
        if (rd_d) chk({1'b0, rdata & msk_q.pop_front()}, {1'b0, exp_q.pop_front()});
    end
    initial begin tick(20000); failures = failures + 1; close_out; end
    ////////////////////////////////////////////////////////////////
    initial begin
        tick(10); i_rstn <= 1'b1; tick(3);
        rd(`OFS_STATUS_FLAGS, 8'h20, 8'hFF);
        rd(`OFS_IRQ_CTRL, 8'h00, 8'hFF); rd(`OFS_ENABLE_CTRL, 8'h00, 8'hFF);
        rd(`OFS_TX_NINTH_BIT, 8'h00, 8'hFF); rd(`OFS_CHAR_CTRL, 8'h03, 8'hFF);
        rd(4'hA, 8'h00, 8'hFF); chk({8'h00, wire_tx}, 9'h001);
        for (i = 0; i < 4; i = i + 1) wr(`OFS_ENABLE_CTRL, 8'h40 | (i << 1));
        wr(`OFS_CHAR_CTRL, {5'h00, `CHSZ_9_LOW_FIRST}); wr(`OFS_CHAR_CTRL, 8'h07);
        d = $random(seed);
        wr(`OFS_TX_NINTH_BIT, 8'h01); wr(`OFS_TX_LOW_BYTE, d);
        rd(`OFS_STATUS_FLAGS, 8'h00, 8'h20); wr(`OFS_TX_LOW_BYTE, ~d); tick(2);
        chk(word, {1'b1, d}); busy <= 1'b1; pulse(0);
        rd(`OFS_STATUS_FLAGS, 8'h20, 8'h60); busy <= 1'b0; tick(3);
        rd(`OFS_STATUS_FLAGS, 8'h60, 8'h60); wr(`OFS_IRQ_CTRL, 8'h40); tick(3);
        chk({8'h00, txv}, 9'h001); pulse(4); chk({8'h00, txv}, 9'h000);
        busy <= 1'b1; tick(2); busy <= 1'b0; tick(3); wr(`OFS_STATUS_FLAGS, 8'h40);
        rd(`OFS_STATUS_FLAGS, 8'h00, 8'h40);
        wr(`OFS_ENABLE_CTRL, 8'hC4); unread <= 1'b1; wr(`OFS_IRQ_CTRL, 8'h84); tick(3);
        chk({8'h00, rxv}, 9'h001); rd(`OFS_STATUS_FLAGS, 8'h80, 8'h80);
        unread <= 1'b0; pulse(1); rd(`OFS_STATUS_FLAGS, 8'h08, 8'h88);
        chk({8'h00, rxv}, 9'h001); wr(`OFS_STATUS_FLAGS, 8'h08); tick(3);
        chk({8'h00, rxv}, 9'h000); rd(`OFS_STATUS_FLAGS, 8'h00, 8'h08);
        wr(`OFS_ENABLE_CTRL, 8'hC6); sync <= 8'h54; pulse(2);
        rd(`OFS_STATUS_FLAGS, 8'h08, 8'h0A); wr(`OFS_STATUS_FLAGS, 8'h08);
        brk <= 1'b1; sync <= `SYNC_CHAR; pulse(2); brk <= 1'b0;
        rd(`OFS_STATUS_FLAGS, 8'h02, 8'h0A); pulse(3);
        rd(`OFS_STATUS_FLAGS, 8'h00, 8'h02); unread <= 1'b1;
        wr(`OFS_ENABLE_CTRL, 8'h40); tick(3); chk({8'h00, flush}, 9'h001);
        rd(`OFS_STATUS_FLAGS, 8'h00, 8'h80); unread <= 1'b0;
        wr(`OFS_ENABLE_CTRL, 8'hD0); stby <= 1'b1; u_serial_node.send(d); tick(3);
        rd(`OFS_STATUS_FLAGS, 8'h10, 8'h10); chk({8'h00, woke}, 9'h001);
        wr(`OFS_STATUS_FLAGS, 8'h10); rd(`OFS_STATUS_FLAGS, 8'h00, 8'h10);
        wr(`OFS_STATUS_FLAGS, 8'h01); rd(`OFS_STATUS_FLAGS, 8'h00, 8'h01); tick(3);
        chk({8'h00, wbk}, 9'h001);
        wr(`OFS_IRQ_CTRL, 8'h20); tick(3); chk({8'h00, dev}, 9'h001);
        close_out;
    end
endmodule // testbench
